// ==== include/bil_pkg.sv ====
// Constants, types and state layout of the boot image loader
package bil_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int BOOT_DLY_NS = 15000;
   localparam int BOOT_DLY_CYC = (BOOT_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [9:0] BOOT_DLY_LAST = 10'(BOOT_DLY_CYC - 1);

   // ****************************************
   // Register addresses
   // ****************************************
   localparam logic [23:0] ADDR_SEC = 24'h000000;
   localparam logic [23:0] ADDR_STATUS = 24'h000004;
   localparam logic [23:0] ADDR_SIZE = 24'h000008;
   localparam logic [23:0] ADDR_CRC = 24'h00000C;
   localparam logic [23:0] ADDR_OTP_ADDR = 24'h100200;
   localparam logic [23:0] ADDR_OTP_DATA = 24'h200100;
   localparam logic [23:0] ADDR_OTP_CTRL = 24'h100300;

   // ****************************************
   // Security word fields
   // ****************************************
   localparam int SEC_JTAG_OFF = 0;
   localparam int SEC_LINK_OFF = 1;
   localparam int SEC_SECURE_BOOT = 5;
   localparam int SEC_REDUNDANT = 7;
   localparam int SEC_SECT_LOCK_LO = 8;
   localparam int SEC_MASTER_LOCK = 12;
   localparam int SEC_JTAG_OTP_OFF = 13;
   localparam int SEC_DEBUG_OFF = 14;
   localparam int SEC_SW_LO = 15;
   localparam int SEC_SW_HI = 21;
   localparam int SEC_UID_LO = 22;
   localparam int SEC_UID_HI = 31;

   // ****************************************
   // Control and status bits
   // ****************************************
   localparam int CTRL_PROG = 0;
   localparam int CTRL_READ = 1;
   localparam int STAT_RUN = 0;
   localparam int STAT_ERR = 1;
   localparam int STAT_REFUSED = 2;
   localparam int STAT_BUSY = 3;

   // ****************************************
   // Image and memories
   // ****************************************
   localparam logic [31:0] BYPASS_MARKER = 32'h0D15AB1E;
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam int OTP_SECTORS = 4;
   localparam int OTP_ROWS_PER_SECTOR = 512;
   localparam int OTP_ROWS = OTP_SECTORS * OTP_ROWS_PER_SECTOR;
   localparam int OTP_AW = 12;
   localparam int OTP_DEPTH = OTP_ROWS + 1;
   localparam logic [11:0] OTP_SEC_ROW = 12'h800;
   localparam int RAM_AW = 15;
   localparam logic [31:0] RAM_WORDS = 32'h00008000;
   localparam logic [14:0] RAM_BASE = 15'h0000;

   typedef enum logic [3:0] {
      BS_HOLD, BS_DELAY, BS_SEC_REQ, BS_SEC_CAP, BS_FETCH, BS_WAIT, BS_CHECK, BS_RUN, BS_ERR
   } bil_state_t;

   typedef struct packed {
      bil_state_t st;
      logic [9:0] dly;
      logic [31:0] sec;
      logic [17:0] cnt;
      logic [31:0] sz;
      logic [31:0] crc;
      logic [31:0] word;
      logic [31:0] chk;
      logic [15:0] oaddr;
      logic [31:0] odata;
      logic [15:0] octl;
      logic refused;
      logic rd_pend;
      logic [31:0] rdata;
      logic ram_we;
      logic [14:0] ram_addr;
      logic [31:0] ram_wdata;
      logic flash_rd;
      logic [23:0] flash_addr;
   } bil_regs_t;

   localparam bil_regs_t BIL_RESET = '{st: BS_HOLD, default: '0};

endpackage

// ==== src/bil_otp_mem.sv ====
// One-time-programmable row array with registered read data
`timescale 1ns/1ns
`default_nettype none
module bil_otp_mem
   import bil_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic ce_in,
   input wire logic wr_in,
   input wire logic [11:0] waddr_in,
   input wire logic [31:0] wdata_in,
   input wire logic rd_in,
   input wire logic [11:0] raddr_in,
   output logic [31:0] rdata_out
);

   logic [31:0] mem [OTP_DEPTH];

   // ****************************************
   // Unprogrammed fuses read as zero
   // ****************************************
   initial begin
      for (int i = 0; i < OTP_DEPTH; i++) begin
         mem[i] = 32'h00000000;
      end
   end

   // ****************************************
   // Fuses only ever go from zero to one, so programming ORs into the row
   // ****************************************
   always_ff @(posedge sys_clk_in) begin
      if (ce_in) begin
         if (wr_in && (int'(waddr_in) < OTP_DEPTH)) begin
            mem[waddr_in] <= mem[waddr_in] | wdata_in;
         end
         if (rd_in) begin
            rdata_out <= (int'(raddr_in) < OTP_DEPTH) ? mem[raddr_in] : 32'h00000000;
         end
      end
   end

endmodule
`default_nettype wire

// ==== src/bil_boot_loader.sv ====
// Boot image loader and tile security configuration
`timescale 1ns/1ns
`default_nettype none
module bil_boot_loader
   import bil_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic dev_rst_n_in,
   output logic gpio_pulldown_out,
   output logic flash_rd_out,
   output logic [23:0] flash_addr_out,
   input wire logic [7:0] flash_data_in,
   input wire logic flash_valid_in,
   output logic ram_we_out,
   output logic [14:0] ram_addr_out,
   output logic [31:0] ram_wdata_out,
   output logic core_run_out,
   output logic [14:0] core_start_addr_out,
   output logic boot_err_out,
   input wire logic [23:0] bus_addr_in,
   input wire logic [31:0] bus_wdata_in,
   input wire logic bus_wr_in,
   input wire logic bus_rd_in,
   input wire logic bus_from_jtag_in,
   output logic [31:0] bus_rdata_out,
   output logic jtag_block_out,
   output logic link_block_out,
   output logic otp_redundant_en_out,
   output logic [9:0] usercode_ext_out,
   input wire logic debug_break_in,
   input wire logic debug_n_in,
   output logic debug_n_out,
   output logic debug_n_oe_out,
   output logic debug_req_out
);

   bil_regs_t r;
   bil_regs_t n;
   logic mem_wr;
   logic mem_rd;
   logic [11:0] mem_raddr;
   logic [31:0] mem_rdata;
   logic secure;
   logic boot_done;
   logic otp_deny;
   logic got;
   logic [7:0] byte_in;
   logic [17:0] data_end;
   logic [31:0] sz_new;
   logic [31:0] crc_new;
   logic [31:0] rd_mux;
   logic lock_hit;

   // ****************************************
   // Reflected CRC-32, one byte at a time
   // ****************************************
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] x;
      x = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++) begin
         x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
      end
      return x;
   endfunction

   // ****************************************
   // OTP array
   // ****************************************
   bil_otp_mem u_otp (
      .sys_clk_in(sys_clk_in),
      .ce_in(ce_in),
      .wr_in(mem_wr),
      .waddr_in(r.oaddr[11:0]),
      .wdata_in(r.odata),
      .rd_in(mem_rd),
      .raddr_in(mem_raddr),
      .rdata_out(mem_rdata)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      n = r;
      n.ram_we = 1'b0;
      n.flash_rd = 1'b0;
      // Read data stand one cycle
      n.rdata = 32'h00000000;
      mem_wr = 1'b0;
      mem_rd = 1'b0;
      mem_raddr = OTP_SEC_ROW;
      secure = r.sec[SEC_SECURE_BOOT];
      boot_done = (r.st == BS_RUN) || (r.st == BS_ERR);
      // Test port OTP access cut
      otp_deny = bus_from_jtag_in && r.sec[SEC_JTAG_OTP_OFF];
      got = 1'b0;
      byte_in = 8'h00;
      // First check byte index
      data_end = 18'd4 + {r.sz[15:0], 2'b00};
      sz_new = {byte_in, r.sz[31:8]};
      crc_new = r.crc;
      lock_hit = 1'b0;
      rd_mux = 32'h00000000;

      // Boot sequencer
      if (!dev_rst_n_in) begin
         n.st = BS_HOLD;
         n.dly = 10'h000;
      end else begin
         unique case (r.st)
            BS_HOLD: begin
               // One idle cycle first
               n.st = BS_DELAY;
               n.dly = 10'h000;
            end
            BS_DELAY: begin
               // Internal reset and clock relock time before the first fetch
               if (r.dly == BOOT_DLY_LAST) begin
                  n.st = BS_SEC_REQ;
               end else begin
                  n.dly = r.dly + 10'h001;
               end
            end
            BS_SEC_REQ: begin
               mem_rd = 1'b1;
               mem_raddr = OTP_SEC_ROW;
               n.st = BS_SEC_CAP;
            end
            BS_SEC_CAP: begin
               // Shadow reloads each boot
               n.sec = mem_rdata;
               n.cnt = 18'h00000;
               n.sz = 32'h00000000;
               n.crc = CRC_INIT;
               n.st = BS_FETCH;
            end
            BS_FETCH: begin
               if (secure) begin
                  // Image rows start at OTP row zero, boot ROM skipped
                  if (r.cnt[17:13] != 5'h00) begin
                     n.st = BS_ERR;
                  end else begin
                     mem_rd = 1'b1;
                     mem_raddr = {1'b0, r.cnt[12:2]};
                     n.st = BS_WAIT;
                  end
               end else begin
                  // One byte per request
                  n.flash_rd = 1'b1;
                  n.flash_addr = {6'h00, r.cnt};
                  n.st = BS_WAIT;
               end
            end
            BS_WAIT: begin
               // Flash may stall any time
               if (secure) begin
                  got = 1'b1;
                  byte_in = mem_rdata[8 * r.cnt[1:0] +: 8];
               end else if (flash_valid_in) begin
                  got = 1'b1;
                  byte_in = flash_data_in;
               end
               sz_new = {byte_in, r.sz[31:8]};
               // Kept only where due
               crc_new = crc_byte(r.crc, byte_in);
               if (got) begin
                  n.cnt = r.cnt + 18'h00001;
                  n.st = BS_FETCH;
                  if (r.cnt < 18'd4) begin
                     n.sz = sz_new;
                     n.crc = crc_new;
                     // A count beyond RAM can never load, so stop early
                     if ((r.cnt == 18'd3) && (sz_new > RAM_WORDS)) begin
                        n.st = BS_ERR;
                     end
                  end else if (r.cnt < data_end) begin
                     n.crc = crc_new;
                     n.word = {byte_in, r.word[31:8]};
                     if (r.cnt[1:0] == 2'b11) begin
                        n.ram_we = 1'b1;
                        n.ram_addr = RAM_BASE + 15'(r.cnt[16:2] - 15'h0001);
                        n.ram_wdata = {byte_in, r.word[31:8]};
                     end
                  end else begin
                     n.chk = {byte_in, r.chk[31:8]};
                     if (r.cnt == data_end + 18'd3) begin
                        n.st = BS_CHECK;
                     end
                  end
               end
            end
            BS_CHECK: begin
               // Marker wins over the CRC
               if ((r.chk == BYPASS_MARKER) || (r.chk == ~r.crc)) begin
                  n.st = BS_RUN;
               end else begin
                  n.st = BS_ERR;
               end
            end
            BS_RUN: begin
               // Left only by device reset
               n.st = BS_RUN;
            end
            BS_ERR: begin
               n.st = BS_ERR;
            end
            default: begin
               n.st = BS_HOLD;
            end
         endcase
      end

      // Pending OTP read lands before any bus write of the data port
      if (r.rd_pend) begin
         n.rd_pend = 1'b0;
         n.odata = mem_rdata;
      end

      // Register writes
      if (bus_wr_in) begin
         if (bus_addr_in == ADDR_STATUS) begin
            if (bus_wdata_in[STAT_REFUSED]) begin
               n.refused = 1'b0;
            end
         end else if ((bus_addr_in == ADDR_OTP_ADDR) && !otp_deny) begin
            n.oaddr = bus_wdata_in[15:0];
         end else if ((bus_addr_in == ADDR_OTP_DATA) && !otp_deny) begin
            n.odata = bus_wdata_in;
         end else if ((bus_addr_in == ADDR_OTP_CTRL) && !otp_deny) begin
            n.octl = bus_wdata_in[15:0];
            // Sector taken from row bits 10:9, four sectors of 512 rows
            lock_hit = r.sec[SEC_SECT_LOCK_LO + int'(r.oaddr[10:9])]
                       && (r.oaddr[11:0] != OTP_SEC_ROW);
            // Refusal stays until cleared
            if (bus_wdata_in[CTRL_PROG]) begin
               if (!boot_done || r.sec[SEC_MASTER_LOCK] || lock_hit
                   || (r.oaddr > {4'h0, OTP_SEC_ROW})) begin
                  n.refused = 1'b1;
               end else begin
                  mem_wr = 1'b1;
               end
            end
            // Array port free after boot
            if (bus_wdata_in[CTRL_READ] && boot_done && (r.oaddr <= {4'h0, OTP_SEC_ROW})) begin
               mem_rd = 1'b1;
               mem_raddr = r.oaddr[11:0];
               n.rd_pend = 1'b1;
            end
         end
      end

      // Register reads; unmapped and denied addresses answer zero
      if (bus_addr_in == ADDR_SEC) begin
         rd_mux = r.sec;
      end else if (bus_addr_in == ADDR_STATUS) begin
         rd_mux[STAT_RUN] = (r.st == BS_RUN);
         rd_mux[STAT_ERR] = (r.st == BS_ERR);
         rd_mux[STAT_REFUSED] = r.refused;
         rd_mux[STAT_BUSY] = !boot_done || r.rd_pend;
      end else if (bus_addr_in == ADDR_SIZE) begin
         rd_mux = r.sz;
      end else if (bus_addr_in == ADDR_CRC) begin
         rd_mux = ~r.crc;
      end else if ((bus_addr_in == ADDR_OTP_ADDR) && !otp_deny) begin
         rd_mux = {16'h0000, r.oaddr};
      end else if ((bus_addr_in == ADDR_OTP_DATA) && !otp_deny) begin
         rd_mux = r.odata;
      end else if ((bus_addr_in == ADDR_OTP_CTRL) && !otp_deny) begin
         rd_mux = {16'h0000, r.octl};
      end
      if (bus_rd_in) begin
         n.rdata = rd_mux;
      end
   end

   // ****************************************
   // State register
   // ****************************************
   // Clock enable low freezes all; rst_in still resets
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         r <= BIL_RESET;
      end else if (ce_in) begin
         r <= n;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Pull-downs follow the pin directly so they act without waiting a clock
   assign gpio_pulldown_out = !dev_rst_n_in || rst_in;
   assign flash_rd_out = r.flash_rd;
   assign flash_addr_out = r.flash_addr;
   assign ram_we_out = r.ram_we;
   assign ram_addr_out = r.ram_addr;
   assign ram_wdata_out = r.ram_wdata;
   assign core_run_out = (r.st == BS_RUN);
   assign core_start_addr_out = RAM_BASE;
   assign boot_err_out = (r.st == BS_ERR);
   assign bus_rdata_out = r.rdata;
   assign jtag_block_out = r.sec[SEC_JTAG_OFF];
   assign link_block_out = r.sec[SEC_LINK_OFF];
   assign otp_redundant_en_out = r.sec[SEC_REDUNDANT];
   assign usercode_ext_out = r.sec[SEC_UID_HI:SEC_UID_LO];
   // Open-drain: only ever pulls low, and never while the debug pin is disabled
   assign debug_n_out = 1'b0;
   assign debug_n_oe_out = debug_break_in && !r.sec[SEC_DEBUG_OFF];
   assign debug_req_out = !debug_n_in && !r.sec[SEC_DEBUG_OFF];

endmodule
`default_nettype wire

// ==== tb/bil_boot_loader_sva.sv ====
// Assertion checker of the boot image loader ports
`timescale 1ns/1ns
`default_nettype none
module bil_boot_loader_sva
   import bil_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic dev_rst_n_in,
   input wire logic gpio_pulldown_out,
   input wire logic flash_rd_out,
   input wire logic ram_we_out,
   input wire logic [14:0] ram_addr_out,
   input wire logic core_run_out,
   input wire logic [14:0] core_start_addr_out,
   input wire logic boot_err_out,
   input wire logic debug_break_in,
   input wire logic debug_n_in,
   input wire logic debug_n_out,
   input wire logic debug_n_oe_out,
   input wire logic debug_req_out
);
   // ****
   // Helpers
   // ****
   logic [15:0] up_r;
   logic [14:0] wr_r;
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || !dev_rst_n_in) begin
         up_r <= 16'h0000;
         wr_r <= 15'h0000;
      end else begin
         // Saturates so a long run never wraps under the boot delay
         up_r <= (up_r == 16'hFFFF) ? up_r : up_r + 16'h0001;
         wr_r <= ram_we_out ? wr_r + 15'h0001 : wr_r;
      end
   end
   // ****
   // Properties
   // ****
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   a_pulldown_in_reset: assert property (!dev_rst_n_in |-> gpio_pulldown_out)
      else $error("pull-down off in reset");
   a_hold_in_reset: assert property (!dev_rst_n_in |=> !core_run_out && !flash_rd_out && !ram_we_out)
      else $error("activity in reset");
   a_boot_delay_min: assert property ((flash_rd_out || ram_we_out || core_run_out) |-> up_r >= 16'h02EE)
      else $error("boot too early");
   a_start_at_zero: assert property (core_run_out |-> core_start_addr_out == RAM_BASE)
      else $error("start address not zero");
   a_ram_in_order: assert property (dev_rst_n_in && ram_we_out |-> ram_addr_out == wr_r)
      else $error("ram address out of order");
   a_run_holds: assert property (core_run_out && dev_rst_n_in |=> core_run_out)
      else $error("run dropped");
   a_run_err_apart: assert property (core_run_out |-> !boot_err_out)
      else $error("run with error");
   a_one_request: assert property (flash_rd_out |=> !flash_rd_out)
      else $error("requests too close");
   a_debug_drive: assert property (debug_n_oe_out |-> debug_break_in && !debug_n_out)
      else $error("debug pin driven wrongly");
   a_debug_request: assert property (debug_req_out |-> !debug_n_in)
      else $error("debug request without pin low");
   c_run: cover property (core_run_out);
   c_err: cover property (boot_err_out);
   c_debug: cover property (debug_n_oe_out);
endmodule
bind bil_boot_loader bil_boot_loader_sva u_sva (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .dev_rst_n_in(dev_rst_n_in),
   .gpio_pulldown_out(gpio_pulldown_out), .flash_rd_out(flash_rd_out), .ram_we_out(ram_we_out),
   .ram_addr_out(ram_addr_out), .core_run_out(core_run_out), .core_start_addr_out(core_start_addr_out),
   .boot_err_out(boot_err_out), .debug_break_in(debug_break_in), .debug_n_in(debug_n_in),
   .debug_n_out(debug_n_out), .debug_n_oe_out(debug_n_oe_out), .debug_req_out(debug_req_out)
);
`default_nettype wire

// ==== tb/bil_flash_model.sv ====
// Behavioural model of the embedded flash holding the boot image
`timescale 1ns/1ns
`default_nettype none
module bil_flash_model (
   input wire logic sys_clk_in,
   input wire logic rd_in,
   input wire logic [23:0] addr_in,
   input wire logic [3:0] lat_in,
   output logic [7:0] data_out,
   output logic valid_out
);
   logic [7:0] img [0:63];
   logic pend_r;
   logic [3:0] wait_r;
   logic [5:0] addr_r;
   initial begin
      pend_r = 1'b0;
      valid_out = 1'b0;
      data_out = 8'h00;
   end
   always @(posedge sys_clk_in) begin
      valid_out <= 1'b0;
      // Outside a valid cycle the byte toggles, so stale data never looks right
      data_out <= ~data_out;
      if (rd_in) begin
         pend_r <= 1'b1;
         addr_r <= addr_in[5:0];
         wait_r <= lat_in;
      end else if (pend_r) begin
         if (wait_r == 4'h0) begin
            valid_out <= 1'b1;
            data_out <= img[addr_r]; // Bytes in image order
            pend_r <= 1'b0;
         end else begin
            wait_r <= wait_r - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/bil_boot_loader_bench.sv ====
// Self-checking testbench of the boot image loader
`timescale 1ns/1ns
`default_nettype none
module bil_boot_loader_bench
   import bil_pkg::*;
();
   logic sys_clk_in, rst_in, ce_in, dev_rst_n_in, flash_valid_in, flash_rd_out, ext_low;
   logic bus_wr_in, bus_rd_in, bus_from_jtag_in, debug_break_in, debug_n_in, debug_n_out;
   logic gpio_pulldown_out, ram_we_out, core_run_out, boot_err_out, jtag_block_out, link_block_out;
   logic otp_redundant_en_out, debug_n_oe_out, debug_req_out;
   logic [7:0] flash_data_in;
   logic [3:0] lat;
   logic [9:0] usercode_ext_out;
   logic [14:0] ram_addr_out, core_start_addr_out;
   logic [23:0] flash_addr_out, bus_addr_in;
   logic [31:0] ram_wdata_out, bus_wdata_in, bus_rdata_out, exp_crc;
   logic [31:0] ram_seen [0:3];
   int num_errors, check_count, ram_n, rd_n;
   bil_boot_loader u_bil_boot_loader (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in), .dev_rst_n_in(dev_rst_n_in),
      .gpio_pulldown_out(gpio_pulldown_out), .flash_rd_out(flash_rd_out), .flash_addr_out(flash_addr_out),
      .flash_data_in(flash_data_in), .flash_valid_in(flash_valid_in), .ram_we_out(ram_we_out),
      .ram_addr_out(ram_addr_out), .ram_wdata_out(ram_wdata_out), .core_run_out(core_run_out),
      .core_start_addr_out(core_start_addr_out), .boot_err_out(boot_err_out), .bus_addr_in(bus_addr_in),
      .bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
      .bus_from_jtag_in(bus_from_jtag_in), .bus_rdata_out(bus_rdata_out), .jtag_block_out(jtag_block_out),
      .link_block_out(link_block_out), .otp_redundant_en_out(otp_redundant_en_out),
      .usercode_ext_out(usercode_ext_out), .debug_break_in(debug_break_in), .debug_n_in(debug_n_in),
      .debug_n_out(debug_n_out), .debug_n_oe_out(debug_n_oe_out), .debug_req_out(debug_req_out)
   );
   bil_flash_model u_bil_flash_model (
      .sys_clk_in(sys_clk_in), .rd_in(flash_rd_out), .addr_in(flash_addr_out), .lat_in(lat),
      .data_out(flash_data_in), .valid_out(flash_valid_in)
   );
   // Pulled-up pin, low when either side pulls it
   assign debug_n_in = !ext_low && !(debug_n_oe_out && !debug_n_out);
   initial begin
      sys_clk_in = 1'b0;
      forever #10 sys_clk_in = ~sys_clk_in;
   end
   always @(posedge sys_clk_in) begin
      if (ram_we_out) begin
         ram_seen[ram_addr_out[1:0]] = ram_wdata_out;
         ram_n++;
      end
      if (flash_rd_out) begin
         rd_n++;
      end
   end
   // ****
   // Shared tasks
   // ****
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (num_errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic bus_wr(input logic [23:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      bus_addr_in <= a;
      bus_wdata_in <= d;
      bus_wr_in <= 1'b1;
      @(posedge sys_clk_in);
      bus_wr_in <= 1'b0;
   endtask
   task automatic bus_rd(input logic [23:0] a, output logic [31:0] d);
      @(posedge sys_clk_in);
      bus_addr_in <= a;
      bus_rd_in <= 1'b1;
      @(posedge sys_clk_in);
      bus_rd_in <= 1'b0;
      @(negedge sys_clk_in);
      d = bus_rdata_out;
   endtask
   task automatic prog(input logic [15:0] row, input logic [31:0] val);
      bus_wr(ADDR_OTP_ADDR, {16'h0000, row});
      bus_wr(ADDR_OTP_DATA, val);
      bus_wr(ADDR_OTP_CTRL, 32'h00000001);
   endtask
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] w);
      logic [31:0] r;
      r = c;
      // Reflected form: bit 0 of the first byte goes in first
      for (int i = 0; i < 32; i++) begin
         r = (r[0] ^ w[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction
   task automatic load_img(input logic [31:0] w0, input logic [31:0] w1, input logic [1:0] mode);
      logic [31:0] wd [0:3];
      logic [31:0] crc;
      crc = crc_step(crc_step(crc_step(CRC_INIT, 32'h00000002), w0), w1);
      exp_crc = ~crc;
      wd[0] = 32'h00000002;
      wd[1] = w0;
      wd[2] = w1;
      wd[3] = (mode == 2'h2) ? BYPASS_MARKER : (exp_crc ^ {31'h00000000, mode[0]});
      for (int i = 0; i < 16; i++) begin
         u_bil_flash_model.img[i] = wd[i / 4][8 * (i % 4) +: 8];
      end
   endtask
   task automatic boot(output int t_first);
      int n;
      @(posedge sys_clk_in);
      dev_rst_n_in <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      check("reset", 32'({gpio_pulldown_out, core_run_out, boot_err_out}), 32'h4);
      ram_n = 0;
      rd_n = 0;
      t_first = 0;
      @(posedge sys_clk_in);
      dev_rst_n_in <= 1'b1;
      for (n = 1; n < 20000; n++) begin
         @(posedge sys_clk_in);
         if (t_first == 0 && (flash_rd_out || ram_we_out)) begin
            t_first = n;
         end
         if (core_run_out || boot_err_out) begin
            break;
         end
      end
      if (n >= 20000) begin
         num_errors++;
         finish_test();
      end
      @(negedge sys_clk_in);
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_good();
      int t;
      logic [31:0] d;
      lat = 4'h0;
      load_img(32'h11223344, 32'hA5C30F1E, 2'h0);
      boot(t);
      check("boot time", 32'(t >= 750 && t <= 7500), 32'h1);
      check("run", 32'({core_run_out, boot_err_out, gpio_pulldown_out}), 32'h4);
      check("words", 32'(ram_n), 32'h2);
      check("ram 0", ram_seen[0], 32'h11223344);
      check("ram 1", ram_seen[1], 32'hA5C30F1E);
      bus_rd(ADDR_SIZE, d);
      check("size", d, 32'h2);
      bus_rd(ADDR_CRC, d);
      check("crc", d, exp_crc);
   endtask
   task automatic t_bad();
      int t;
      logic [31:0] d;
      lat = 4'h3;
      load_img(32'h80000001, 32'h0000FFFF, 2'h1);
      boot(t);
      check("bad run", 32'({core_run_out, boot_err_out}), 32'h1);
      bus_rd(ADDR_STATUS, d);
      check("bad status", 32'(d[1:0]), 32'h2);
   endtask
   task automatic t_bypass();
      int t;
      logic [31:0] d;
      lat = 4'h1;
      load_img(32'h00000000, 32'hFFFFFFFF, 2'h2);
      boot(t);
      check("bypass", 32'({core_run_out, boot_err_out}), 32'h2);
      bus_wr(ADDR_SEC, 32'hFFFFFFFF);
      bus_rd(ADDR_SEC, d);
      check("sec ro", d, 32'h0);
      bus_rd(24'h000010, d);
      check("unmapped", d, 32'h0);
      @(posedge sys_clk_in);
      debug_break_in <= 1'b1;
      @(negedge sys_clk_in);
      check("dbg drive", 32'({debug_n_oe_out, debug_n_in, debug_req_out}), 32'h5);
      @(posedge sys_clk_in);
      debug_break_in <= 1'b0;
      ext_low <= 1'b1;
      @(negedge sys_clk_in);
      check("dbg in", 32'({debug_n_oe_out, debug_req_out}), 32'h1);
      @(posedge sys_clk_in);
      ext_low <= 1'b0;
   endtask
   task automatic t_secure();
      int t;
      logic [31:0] d;
      prog(16'h0000, 32'h00000001);
      prog(16'h0001, 32'hCAFE0123);
      prog(16'h0002, BYPASS_MARKER);
      prog(16'h0800, 32'hA940F1A3);
      bus_wr(ADDR_OTP_ADDR, 32'h00000001);
      bus_wr(ADDR_OTP_CTRL, 32'h00000002);
      bus_rd(ADDR_OTP_DATA, d);
      check("otp row", d, 32'hCAFE0123);
      boot(t);
      check("flags", 32'({core_run_out, jtag_block_out, link_block_out, otp_redundant_en_out}), 32'hF);
      check("flash reads", 32'(rd_n), 32'h0);
      check("otp image", ram_seen[0], 32'hCAFE0123);
      check("user code", 32'(usercode_ext_out), 32'h2A5);
      bus_rd(ADDR_SEC, d);
      check("security", d, 32'hA940F1A3);
      @(posedge sys_clk_in);
      bus_from_jtag_in <= 1'b1;
      bus_rd(ADDR_OTP_DATA, d);
      check("jtag otp", d, 32'h0);
      @(posedge sys_clk_in);
      bus_from_jtag_in <= 1'b0;
      @(posedge sys_clk_in);
      debug_break_in <= 1'b1;
      ext_low <= 1'b1;
      @(negedge sys_clk_in);
      check("dbg off", 32'({debug_n_oe_out, debug_req_out}), 32'h0);
      @(posedge sys_clk_in);
      debug_break_in <= 1'b0;
      ext_low <= 1'b0;
      prog(16'h0003, 32'h00000001);
      bus_rd(ADDR_STATUS, d);
      check("locked", 32'(d[2]), 32'h1);
      bus_wr(ADDR_STATUS, 32'h00000004);
      prog(16'h0200, 32'h00000001);
      bus_rd(ADDR_STATUS, d);
      check("master lock", 32'(d[2]), 32'h1);
   endtask
   initial begin
      rst_in = 1'b1;
      ce_in = 1'b1;
      dev_rst_n_in = 1'b0;
      bus_addr_in = 24'h000000;
      bus_wdata_in = 32'h00000000;
      bus_wr_in = 1'b0;
      bus_rd_in = 1'b0;
      bus_from_jtag_in = 1'b0;
      debug_break_in = 1'b0;
      ext_low = 1'b0;
      lat = 4'h0;
      num_errors = 0;
      check_count = 0;
      repeat (16) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      // Supply good 1 ms (50000 cycles) first
      repeat (50000) @(posedge sys_clk_in);
      t_good();
      t_bad();
      t_bypass();
      t_secure();
      finish_test();
   end
endmodule
`default_nettype wire
